// ===== hdl/icst_idle_timer.sv
// Operation
// (R1) E3h and 97h both start idle-with-timer
// (R2) accept: enter idle, load timer from count
// (R3) timer decrements immediately after loading; the code first decrements one full tick (TICK_CYCLES cycles) after the load
// (R4) spin up on idle, skip if spinning
// (R5) idle keeps spinning, serves commands without delay
// (R6) code zero disables power-down, nonzero enables
// (R7) codes 1-240: code times five seconds
// (R8) codes 241-251: (code-240) times thirty minutes
// (R9) codes 252-255 map to fixed intervals
// (R10) interval elapses untouched: enter standby; the code does this from idle only, and an expiry during spin-up is ignored
// (R11) host access before expiry reloads full interval
// (R12) failed command: error flag plus aborted bit
// (R13) any written command counts as access
`timescale 1ns/10ps
`default_nettype none
module icst_idle_timer
    import icst_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // task-file access
    input wire logic [2:0] HOST_ADDR,
    input wire logic HOST_WR,
    input wire logic HOST_RD,
    input wire logic [7:0] HOST_WDATA,
    output logic [7:0] HOST_RDATA,
    // spindle
    input wire logic SPIN_AT_SPEED,
    output logic MOTOR_ON,
    // power state
    output logic IDLE_MODE,
    output logic STANDBY_MODE,
    output logic TIMER_ENABLED
);

    icst_pwr_t pwr_q;
    icst_pwr_t pwr_d;
    logic [7:0] seccnt_q;
    logic [7:0] seccnt_d;
    logic [7:0] devhead_q;
    logic [7:0] devhead_d;
    logic [7:0] err_q;
    logic [7:0] err_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [SECS_W-1:0] interval_q;
    logic [SECS_W-1:0] interval_d;
    logic spin_meta_q;
    logic spin_sync_q;

    logic busy;
    logic wr_seccnt;
    logic wr_devhead;
    logic wr_cmd;
    logic is_idle_cmd;
    logic accept;
    logic reject;
    logic access;
    logic timer_load;
    logic expire;
    logic [SECS_W-1:0] new_secs;
    logic [SECS_W-1:0] load_secs;
    logic [SECS_W-1:0] remain;
    logic [7:0] status;

    // spindle speed pin synchroniser
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            spin_meta_q <= 1'b0;
            spin_sync_q <= 1'b0;
        end else begin
            spin_meta_q <= SPIN_AT_SPEED;
            spin_sync_q <= spin_meta_q;
        end
    end

    // register decode
    assign busy = pwr_q == PWR_SPINUP;
    assign wr_seccnt = HOST_WR && (HOST_ADDR == ADDR_SECCNT) && !busy;
    assign wr_devhead = HOST_WR && (HOST_ADDR == ADDR_DEVHEAD) && !busy;
    assign wr_cmd = HOST_WR && (HOST_ADDR == ADDR_CMD) && !busy;
    assign is_idle_cmd = (HOST_WDATA == CMD_IDLE) || (HOST_WDATA == CMD_IDLE_ALT); // R1
    assign accept = wr_cmd && is_idle_cmd; // R1
    assign reject = wr_cmd && !is_idle_cmd; // R12

    // interval from the timeout code
    icst_decode u_decode (
        .code(seccnt_q),
        .secs(new_secs)
    ); // R6 R7 R8 R9

    // a fresh command loads the new interval, any other access while the timer runs reloads the held one
    assign access = HOST_WR || HOST_RD; // R13
    assign timer_load = accept || (access && (remain != '0)); // R2 R11 R13
    assign load_secs = accept ? new_secs : interval_q; // R2 R11

    icst_countdown #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_countdown (
        .clk(CLK),
        .rst_n(RESETN),
        .load(timer_load),
        .load_secs(load_secs),
        .remain_q(remain),
        .expire(expire)
    ); // R3

    assign interval_d = accept ? new_secs : interval_q;
    assign seccnt_d = wr_seccnt ? HOST_WDATA : seccnt_q;
    assign devhead_d = wr_devhead ? HOST_WDATA : devhead_q;
    assign err_d = reject ? ERR_ABT_MASK : (accept ? ERR_RESET : err_q); // R12

    // power state
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PWR_STANDBY: begin
                if (accept) begin
                    pwr_d = spin_sync_q ? PWR_IDLE : PWR_SPINUP; // R2 R4
                end
            end
            PWR_SPINUP: begin
                if (spin_sync_q) begin
                    pwr_d = PWR_IDLE; // R4
                end
            end
            PWR_IDLE: begin
                if (expire) begin
                    pwr_d = PWR_STANDBY; // R10
                end else if (accept && !spin_sync_q) begin
                    pwr_d = PWR_SPINUP; // R4
                end
            end
            default: begin
                pwr_d = PWR_STANDBY;
            end
        endcase
    end

    // status and read-back
    always_comb begin
        status = 8'h00;
        status[ST_BSY] = busy;
        status[ST_RDY] = !busy; // R5
        status[ST_DSC] = spin_sync_q;
        status[ST_IDX] = 1'b1;
        status[ST_ERR] = err_q != ERR_RESET; // R12
    end

    assign rdata_d = (HOST_ADDR == ADDR_ERROR) ? err_q :
                     (HOST_ADDR == ADDR_SECCNT) ? seccnt_q :
                     (HOST_ADDR == ADDR_DEVHEAD) ? devhead_q :
                     (HOST_ADDR == ADDR_CMD) ? status : 8'h00;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pwr_q <= PWR_STANDBY;
            seccnt_q <= SECCNT_RESET;
            devhead_q <= DEVHEAD_RESET;
            err_q <= ERR_RESET;
            rdata_q <= 8'h00;
            interval_q <= '0;
        end else begin
            pwr_q <= pwr_d;
            seccnt_q <= seccnt_d;
            devhead_q <= devhead_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
            interval_q <= interval_d;
        end
    end

    assign HOST_RDATA = rdata_q;
    assign MOTOR_ON = pwr_q != PWR_STANDBY; // R5
    assign IDLE_MODE = pwr_q == PWR_IDLE;
    assign STANDBY_MODE = pwr_q == PWR_STANDBY;
    assign TIMER_ENABLED = remain != '0; // R6

    // checks
    sequence s_accept_spinning;
        accept && spin_sync_q;
    endsequence

    sequence s_accept_still;
        accept && !spin_sync_q;
    endsequence

    sequence s_quiet_expiry;
        (pwr_q == PWR_IDLE) && expire;
    endsequence

    property p_idle_codes;
        @(posedge CLK) disable iff (!RESETN)
        wr_cmd && ((HOST_WDATA == CMD_IDLE) || (HOST_WDATA == CMD_IDLE_ALT)) |=> (pwr_q != PWR_STANDBY) && (err_q == ERR_RESET);
    endproperty
    a_idle_codes: assert property (p_idle_codes) else $error("idle code not accepted"); // R1

    property p_load;
        @(posedge CLK) disable iff (!RESETN)
        accept |=> (remain == $past(new_secs)) && (interval_q == remain);
    endproperty
    a_load: assert property (p_load) else $error("timer not loaded on idle command"); // R2

    property p_countdown;
        @(posedge CLK) disable iff (!RESETN)
        (remain != '0) && !timer_load |=> (remain == $past(remain)) || (remain == $past(remain) - SECS_W'(1));
    endproperty
    a_countdown: assert property (p_countdown) else $error("timer moved other than down by one"); // R3

    property p_spin_skip;
        @(posedge CLK) disable iff (!RESETN)
        s_accept_spinning |=> IDLE_MODE && !busy;
    endproperty
    a_spin_skip: assert property (p_spin_skip) else $error("spin-up run while spinning"); // R4

    property p_spin_up;
        @(posedge CLK) disable iff (!RESETN)
        s_accept_still |=> MOTOR_ON && (pwr_q == PWR_SPINUP) && status[ST_BSY];
    endproperty
    a_spin_up: assert property (p_spin_up) else $error("spin-up not started"); // R4

    property p_idle_ready;
        @(posedge CLK) disable iff (!RESETN)
        IDLE_MODE |-> MOTOR_ON && status[ST_RDY] && !status[ST_BSY];
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("idle mode not ready"); // R5

    property p_zero_off;
        @(posedge CLK) disable iff (!RESETN)
        accept && (seccnt_q == CODE_OFF) |=> !TIMER_ENABLED [*2];
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("timer running with code zero"); // R6

    property p_short;
        @(posedge CLK) disable iff (!RESETN)
        accept && (seccnt_q != CODE_OFF) && (seccnt_q <= CODE_SHORT_MAX)
            |=> remain == 15'({7'h00, $past(seccnt_q)} * SHORT_STEP_S);
    endproperty
    a_short: assert property (p_short) else $error("short interval wrong"); // R7

    property p_half;
        @(posedge CLK) disable iff (!RESETN)
        accept && (seccnt_q > CODE_SHORT_MAX) && (seccnt_q <= CODE_HALF_MAX)
            |=> remain == 15'(({7'h00, $past(seccnt_q)} - {7'h00, CODE_SHORT_MAX}) * HALF_STEP_S);
    endproperty
    a_half: assert property (p_half) else $error("half-hour interval wrong"); // R8

    property p_fixed;
        @(posedge CLK) disable iff (!RESETN)
        accept && (seccnt_q == CODE_8H) |=> remain == T_8H_S;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed interval wrong"); // R9

    property p_expire;
        @(posedge CLK) disable iff (!RESETN)
        s_quiet_expiry |=> STANDBY_MODE && !MOTOR_ON && !TIMER_ENABLED;
    endproperty
    a_expire: assert property (p_expire) else $error("no standby on expiry"); // R10

    property p_reload;
        @(posedge CLK) disable iff (!RESETN)
        access && !accept && (remain != '0) |=> remain == $past(interval_q);
    endproperty
    a_reload: assert property (p_reload) else $error("access did not reload timer"); // R11 R13

    property p_abort;
        @(posedge CLK) disable iff (!RESETN)
        reject |=> (err_q == ERR_ABT_MASK) ##1 (HOST_RDATA[ST_ERR] || (HOST_ADDR != ADDR_CMD) || $past(HOST_ADDR) != ADDR_CMD);
    endproperty
    a_abort: assert property (p_abort) else $error("abort not reported"); // R12

    sequence s_spindle_ready;
        busy && spin_sync_q;
    endsequence

    property p_spun_up;
        @(posedge CLK) disable iff (!RESETN)
        s_spindle_ready |=> IDLE_MODE && status[ST_RDY];
    endproperty
    a_spun_up: assert property (p_spun_up) else $error("spin-up did not end at speed"); // R4

    property p_busy_refuse;
        @(posedge CLK) disable iff (!RESETN)
        busy && HOST_WR
            |=> (seccnt_q == $past(seccnt_q)) && (devhead_q == $past(devhead_q)) && (err_q == $past(err_q));
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("write taken during spin-up"); // R4

    property p_standby_quiet;
        @(posedge CLK) disable iff (!RESETN)
        STANDBY_MODE && !accept |=> STANDBY_MODE && !TIMER_ENABLED;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("standby left without idle command"); // R10

    property p_fixed_21m;
        @(posedge CLK) disable iff (!RESETN)
        accept && (seccnt_q == CODE_21M) |=> remain == T_21M_S;
    endproperty
    a_fixed_21m: assert property (p_fixed_21m) else $error("21 minute interval wrong"); // R9

    property p_fixed_21m10;
        @(posedge CLK) disable iff (!RESETN)
        accept && (seccnt_q == CODE_21M10) |=> remain == T_21M10_S;
    endproperty
    a_fixed_21m10: assert property (p_fixed_21m10) else $error("21 minute 10 second interval wrong"); // R9

    property p_fixed_21m15;
        @(posedge CLK) disable iff (!RESETN)
        accept && (seccnt_q == CODE_21M15) |=> remain == T_21M15_S;
    endproperty
    a_fixed_21m15: assert property (p_fixed_21m15) else $error("21 minute 15 second interval wrong"); // R9

endmodule : icst_idle_timer
`default_nettype wire

// ===== hdl/icst_pkg.sv
package icst_pkg;

    // task-file register addresses
    localparam logic [2:0] ADDR_ERROR = 3'h1;
    localparam logic [2:0] ADDR_SECCNT = 3'h2;
    localparam logic [2:0] ADDR_DEVHEAD = 3'h6;
    localparam logic [2:0] ADDR_CMD = 3'h7;

    // command codes for idle with standby timer
    localparam logic [7:0] CMD_IDLE = 8'hE3;
    localparam logic [7:0] CMD_IDLE_ALT = 8'h97;

    // reset values
    localparam logic [7:0] SECCNT_RESET = 8'h00;
    localparam logic [7:0] DEVHEAD_RESET = 8'hA0;
    localparam logic [7:0] ERR_RESET = 8'h00;

    // status bit positions
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_IDX = 1;
    localparam int ST_ERR = 0;

    // error bit: command aborted
    localparam logic [7:0] ERR_ABT_MASK = 8'h04;

    // timeout code bands
    localparam logic [7:0] CODE_OFF = 8'h00;
    localparam logic [7:0] CODE_SHORT_MAX = 8'hF0;
    localparam logic [7:0] CODE_HALF_MAX = 8'hFB;
    localparam logic [7:0] CODE_21M = 8'hFC;
    localparam logic [7:0] CODE_8H = 8'hFD;
    localparam logic [7:0] CODE_21M10 = 8'hFE;
    localparam logic [7:0] CODE_21M15 = 8'hFF;

    // intervals in base units (seconds)
    localparam int SECS_W = 15;
    localparam int MIN_S = 60;
    localparam int HOUR_S = 3600;
    localparam logic [SECS_W-1:0] SHORT_STEP_S = 15'(5);
    localparam logic [SECS_W-1:0] HALF_STEP_S = 15'(30 * MIN_S);
    localparam logic [SECS_W-1:0] T_21M_S = 15'(21 * MIN_S);
    localparam logic [SECS_W-1:0] T_8H_S = 15'(8 * HOUR_S);
    localparam logic [SECS_W-1:0] T_21M10_S = 15'(21 * MIN_S + 10);
    localparam logic [SECS_W-1:0] T_21M15_S = 15'(21 * MIN_S + 15);

    // base unit timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int BASE_UNIT_NS = 1000000000;
    localparam int TICK_CYCLES_DFLT = BASE_UNIT_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {PWR_STANDBY, PWR_SPINUP, PWR_IDLE} icst_pwr_t;

endpackage : icst_pkg

// ===== hdl/icst_decode.sv
`timescale 1ns/10ps
`default_nettype none
module icst_decode
    import icst_pkg::*;
(
    // timeout code in, interval out
    input wire logic [7:0] code,
    output logic [SECS_W-1:0] secs
);

    logic [SECS_W-1:0] code_w;
    logic [SECS_W-1:0] short_s;
    logic [SECS_W-1:0] half_s;
    logic [SECS_W-1:0] fixed_s;
    logic is_short;
    logic is_half;

    assign code_w = {7'h00, code};
    assign is_short = code <= CODE_SHORT_MAX;
    assign is_half = code <= CODE_HALF_MAX;
    assign short_s = 15'(code_w * SHORT_STEP_S);
    assign half_s = 15'((code_w - {7'h00, CODE_SHORT_MAX}) * HALF_STEP_S);
    assign fixed_s = (code == CODE_21M) ? T_21M_S :
                     (code == CODE_8H) ? T_8H_S :
                     (code == CODE_21M10) ? T_21M10_S : T_21M15_S;
    assign secs = (code == CODE_OFF) ? '0 :
                  is_short ? short_s :
                  is_half ? half_s : fixed_s;

endmodule : icst_decode
`default_nettype wire

// ===== hdl/icst_countdown.sv
`timescale 1ns/10ps
`default_nettype none
module icst_countdown
    import icst_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // load and status
    input wire logic load,
    input wire logic [SECS_W-1:0] load_secs,
    output logic [SECS_W-1:0] remain_q,
    output logic expire
);

    localparam int PRE_W = $clog2(TICK_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] pre_d;
    logic [SECS_W-1:0] remain_d;
    logic tick;
    logic running;

    assign running = remain_q != '0;
    assign tick = running && (pre_q == PRE_LAST);
    assign expire = tick && (remain_q == SECS_W'(1)) && !load;
    assign pre_d = (load || tick || !running) ? '0 : pre_q + PRE_W'(1);
    assign remain_d = load ? load_secs : (tick ? remain_q - SECS_W'(1) : remain_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
            remain_q <= '0;
        end else begin
            pre_q <= pre_d;
            remain_q <= remain_d;
        end
    end

endmodule : icst_countdown
`default_nettype wire

// ===== tb/icst_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module icst_host_model
    import icst_pkg::*;
(
    // clock
    input wire logic clk,
    // task-file side
    output logic [2:0] addr,
    output logic wr,
    output logic rd,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    initial begin
        addr = 3'h0;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // released data must not keep showing the old byte
        wdata <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic idle_cmd(input logic [7:0] code, input bit alt);
        wr_reg(ADDR_SECCNT, code);
        wr_reg(ADDR_CMD, alt ? CMD_IDLE_ALT : CMD_IDLE);
    endtask : idle_cmd
endmodule : icst_host_model
`default_nettype wire

// ===== tb/test_icst_idle_timer.sv
`timescale 1ns/10ps
`default_nettype none
module test_icst_idle_timer;
    import icst_pkg::*;
    localparam int TICK = 4;
    logic clk = 1'b0;
    logic resetn;
    logic spin;
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic motor_on;
    logic idle_mode;
    logic standby_mode;
    logic timer_enabled;
    wire logic [3:0] flags = {motor_on, idle_mode, standby_mode, timer_enabled};
    int err_count = 0;
    int tests_run = 0;
    logic [7:0] d;

    always #12.5 clk = ~clk;

    icst_idle_timer #(.TICK_CYCLES(TICK)) icst_idle_timer_i (
        .CLK(clk), .RESETN(resetn), .HOST_ADDR(addr), .HOST_WR(wr), .HOST_RD(rd),
        .HOST_WDATA(wdata), .HOST_RDATA(rdata), .SPIN_AT_SPEED(spin), .MOTOR_ON(motor_on),
        .IDLE_MODE(idle_mode), .STANDBY_MODE(standby_mode), .TIMER_ENABLED(timer_enabled)
    );

    icst_host_model icst_host_model_i (
        .clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata)
    );

    task automatic complete_run;
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic read_check(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        icst_host_model_i.rd_reg(a, v);
        check(v, exp);
    endtask : read_check

    function automatic int secs_of(input int c);
        if (c <= 240) return c * 5;
        if (c <= 251) return (c - 240) * 1800;
        if (c == 252) return 1260;
        if (c == 253) return 28800;
        if (c == 254) return 1270;
        return 1275;
    endfunction : secs_of

    // counts edges from the load edge to standby
    task automatic wait_standby(input int exp);
        int n;
        n = 0;
        #1;
        while (standby_mode !== 1'b1 && n < exp + 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= exp + 50) begin
            err_count++;
            complete_run();
        end
        check(16'(n), 16'(exp));
    endtask : wait_standby

    task automatic t_reset;
        check(flags, 4'h2);
        read_check(ADDR_CMD, 8'h42);
        read_check(ADDR_SECCNT, SECCNT_RESET);
        read_check(ADDR_DEVHEAD, DEVHEAD_RESET);
        read_check(ADDR_ERROR, ERR_RESET);
        read_check(3'h0, 8'h00);
    endtask : t_reset

    task automatic t_spinup;
        int n;
        icst_host_model_i.idle_cmd(8'h00, 1'b0);
        #1;
        check(flags, 4'b1000);
        read_check(ADDR_CMD, 8'h82);
        icst_host_model_i.wr_reg(ADDR_SECCNT, 8'h55);
        read_check(ADDR_SECCNT, 8'h00);
        @(posedge clk);
        spin <= 1'b1;
        n = 0;
        while (idle_mode !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 10) begin
            err_count++;
            complete_run();
        end
        check(16'(n), 16'h3);
        check(flags, 4'b1100);
        read_check(ADDR_CMD, 8'h52);
        icst_host_model_i.wr_reg(ADDR_DEVHEAD, 8'hB5);
        read_check(ADDR_DEVHEAD, 8'hB5);
        repeat (200) @(posedge clk);
        #1;
        check(flags, 4'b1100);
    endtask : t_spinup

    task automatic t_codes;
        int codes[7] = '{1, 2, 240, 241, 252, 254, 255};
        for (int i = 0; i < 7; i++) begin
            icst_host_model_i.idle_cmd(8'(codes[i]), i[0]);
            #1;
            check(flags, 4'b1101);
            wait_standby(secs_of(codes[i]) * TICK);
            check(flags, 4'b0010);
        end
    endtask : t_codes

    task automatic t_reload;
        icst_host_model_i.idle_cmd(8'h01, 1'b0);
        repeat (12) @(posedge clk);
        read_check(ADDR_SECCNT, 8'h01);
        wait_standby(5 * TICK);
        icst_host_model_i.idle_cmd(8'h01, 1'b1);
        repeat (12) @(posedge clk);
        icst_host_model_i.wr_reg(ADDR_CMD, 8'h00);
        #1;
        check(flags, 4'b1101);
        wait_standby(5 * TICK);
        read_check(ADDR_ERROR, ERR_ABT_MASK);
        read_check(ADDR_CMD, 8'h53);
        icst_host_model_i.idle_cmd(8'hFD, 1'b0);
        #1;
        check(flags, 4'b1101);
        read_check(ADDR_ERROR, 8'h00);
        icst_host_model_i.idle_cmd(8'h00, 1'b1);
        #1;
        check(flags, 4'b1100);
    endtask : t_reload

    // spindle lost in idle, expiry during spin-up, then reset in mid-run
    task automatic t_respin;
        @(posedge clk);
        spin <= 1'b0;
        repeat (3) @(posedge clk);
        icst_host_model_i.idle_cmd(8'h02, 1'b0);
        #1;
        check(flags, 4'h9);
        repeat (45) @(posedge clk);
        #1;
        check(flags, 4'h8);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(flags, 4'h2);
        @(posedge clk);
        resetn <= 1'b1;
        spin <= 1'b1;
        read_check(ADDR_SECCNT, SECCNT_RESET);
        icst_host_model_i.idle_cmd(8'h01, 1'b1);
        #1;
        check(flags, 4'hD);
        wait_standby(5 * TICK);
    endtask : t_respin

    initial begin
        resetn = 1'b0;
        spin = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check(flags, 4'h2);
        @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_spinup();
        t_codes();
        t_reload();
        t_respin();
        complete_run();
    end
endmodule : test_icst_idle_timer
`default_nettype wire
